// >>> include/dpc_defs.vh
// register map, field layout, reset values and scaling constants
`ifndef DPC_DEFS_VH
`define DPC_DEFS_VH

`define DPC_ADDR_W          8
`define DPC_DATA_W          16

`define DPC_ADDR_LOWER      8'h00
`define DPC_ADDR_UPPER      8'h01
`define DPC_ADDR_RANGE      8'h02

`define DPC_UPPER_ZERO_HI   15
`define DPC_UPPER_ZERO_LO   11
`define DPC_UPPER_OE_BIT    10
`define DPC_UPPER_TUNE_HI   9
`define DPC_UPPER_TUNE_LO   0
`define DPC_UPPER_TUNE_W    10

`define DPC_RANGE_ZERO_HI   15
`define DPC_RANGE_ZERO_LO   4
`define DPC_RANGE_HI        3
`define DPC_RANGE_LO        0
`define DPC_RANGE_W         4

`define DPC_LOWER_W         16
`define DPC_TUNE_W          26

`define DPC_RST_LOWER       16'h0000
`define DPC_RST_UPPER_TUNE  10'h000
`define DPC_RST_OE          1'b0
`define DPC_RST_RANGE       4'h0

// full half-scale tune magnitude, 2^25 - 1
`define DPC_TUNE_FULL_SCALE 26'h1FFFFFF

// half pull range in quarter-ppm units, widest is 3200 ppm
`define DPC_HALF_RANGE_W    14
`define DPC_PULL_W          40

`endif

// >>> logic/dpc_regs.v
// register bank for tune word, software output enable and pull range
//
// What this block does
// - upper register bits 15:11 read zero, ignore writes
// - upper bit 10 is output enable, resets low
// - enable bit only matters under software control
// - upper bits 9:0 are tune word top bits
// - whole tune word resets to zero, nominal frequency
// - tune word is signed two's complement
// - only an upper write commits; lower waits
// - range code picks sixteen ascending symmetric ranges
// - range loads factory value, host may overwrite
// - range register bits 15:4 read zero, ignore writes
// - full scale magnitude means full half range
`timescale 1ns/1ps
`include "dpc_defs.vh"

module dpc_regs #(
  parameter ADDR_W = `DPC_ADDR_W,
  parameter DATA_W = `DPC_DATA_W
) (
  input  wire                               clock_i,
  input  wire                               rstn_i,
  input  wire                               reg_wr_i,
  input  wire                               reg_rd_i,
  input  wire [ADDR_W-1:0]                  reg_addr_i,
  input  wire [DATA_W-1:0]                  reg_wdata_i,
  output reg  [DATA_W-1:0]                  reg_rdata_o,
  output reg                                reg_rvalid_o,
  input  wire                               sw_oe_mode_i,
  input  wire                               oe_pin_i,
  input  wire [`DPC_RANGE_W-1:0]            factory_range_i,
  output reg                                output_enable_o,
  output reg  signed [`DPC_TUNE_W-1:0]      tune_word_o,
  output reg  [`DPC_RANGE_W-1:0]            range_code_o,
  output reg  [`DPC_HALF_RANGE_W-1:0]       half_range_o,
  output reg  signed [`DPC_PULL_W-1:0]      pull_scaled_o,
  output reg                                tune_update_o
);

  // half pull range in quarter-ppm for each range code
  function [`DPC_HALF_RANGE_W-1:0] range_to_quarter_ppm;
    input [`DPC_RANGE_W-1:0] code;
    begin
      case (code)
        4'h0:    range_to_quarter_ppm = 14'h0019;
        4'h1:    range_to_quarter_ppm = 14'h0028;
        4'h2:    range_to_quarter_ppm = 14'h0032;
        4'h3:    range_to_quarter_ppm = 14'h0064;
        4'h4:    range_to_quarter_ppm = 14'h00C8;
        4'h5:    range_to_quarter_ppm = 14'h0140;
        4'h6:    range_to_quarter_ppm = 14'h0190;
        4'h7:    range_to_quarter_ppm = 14'h01F4;
        4'h8:    range_to_quarter_ppm = 14'h0258;
        4'h9:    range_to_quarter_ppm = 14'h0320;
        4'hA:    range_to_quarter_ppm = 14'h0640;
        4'hB:    range_to_quarter_ppm = 14'h0960;
        4'hC:    range_to_quarter_ppm = 14'h0C80;
        4'hD:    range_to_quarter_ppm = 14'h12C0;
        4'hE:    range_to_quarter_ppm = 14'h1900;
        default: range_to_quarter_ppm = 14'h3200;
      endcase
    end
  endfunction

  // signed tune times half range; divide by full scale downstream
  function signed [`DPC_PULL_W-1:0] scale_pull;
    input signed [`DPC_TUNE_W-1:0]  tune;
    input [`DPC_HALF_RANGE_W-1:0]   half;
    reg signed [`DPC_HALF_RANGE_W:0] half_s;
    begin
      half_s     = {1'b0, half};
      scale_pull = tune * half_s;
    end
  endfunction

  reg  [`DPC_LOWER_W-1:0]       lower_q;
  reg  [`DPC_UPPER_TUNE_W-1:0]  upper_q;
  reg                           oe_q;
  reg  [`DPC_RANGE_W-1:0]       range_q;
  reg                           factory_pend_q;
  reg                           oe_pin_meta_q;
  reg                           oe_pin_sync_q;

  wire wr_lower = reg_wr_i && (reg_addr_i == `DPC_ADDR_LOWER);
  wire wr_upper = reg_wr_i && (reg_addr_i == `DPC_ADDR_UPPER);
  wire wr_range = reg_wr_i && (reg_addr_i == `DPC_ADDR_RANGE);

  // factory code folds in here so an upper write on the strap edge
  // commits the same range that the readable copy takes
  wire [`DPC_RANGE_W-1:0] range_d =
    wr_range       ? reg_wdata_i[`DPC_RANGE_HI:`DPC_RANGE_LO] :
    factory_pend_q ? factory_range_i : range_q;

  wire signed [`DPC_TUNE_W-1:0] tune_d =
    {reg_wdata_i[`DPC_UPPER_TUNE_HI:`DPC_UPPER_TUNE_LO], lower_q};

  // oe pin is asynchronous to the register clock
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      oe_pin_meta_q <= 1'b0;
      oe_pin_sync_q <= 1'b0;
    end else begin
      oe_pin_meta_q <= oe_pin_i;
      oe_pin_sync_q <= oe_pin_meta_q;
    end
  end

  // staging and readable copies
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      lower_q        <= `DPC_RST_LOWER;
      upper_q        <= `DPC_RST_UPPER_TUNE;
      oe_q           <= `DPC_RST_OE;
      range_q        <= `DPC_RST_RANGE;
      factory_pend_q <= 1'b1;
    end else begin
      // a held lower word only becomes live on the next upper write
      if (wr_lower)
        lower_q <= reg_wdata_i;
      if (wr_upper) begin
        upper_q <= reg_wdata_i[`DPC_UPPER_TUNE_HI:`DPC_UPPER_TUNE_LO];
        oe_q    <= reg_wdata_i[`DPC_UPPER_OE_BIT];
      end
      // strap is caught one edge after release; a host write that
      // same edge wins since it is the newer intent
      factory_pend_q <= 1'b0;
      if (wr_range || factory_pend_q)
        range_q <= range_d;
    end
  end

  // committed view seen by the pulling logic, all from one edge
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      tune_word_o   <= {`DPC_TUNE_W{1'b0}};
      range_code_o  <= `DPC_RST_RANGE;
      half_range_o  <= range_to_quarter_ppm(`DPC_RST_RANGE);
      pull_scaled_o <= {`DPC_PULL_W{1'b0}};
      tune_update_o <= 1'b0;
    end else begin
      tune_update_o <= 1'b0;
      if (wr_upper) begin
        tune_word_o   <= tune_d;
        range_code_o  <= range_d;
        half_range_o  <= range_to_quarter_ppm(range_d);
        pull_scaled_o <= scale_pull(tune_d,
                                    range_to_quarter_ppm(range_d));
        tune_update_o <= 1'b1;
      end else if (wr_range || factory_pend_q) begin
        // range change rescales the already committed word
        range_code_o  <= range_d;
        half_range_o  <= range_to_quarter_ppm(range_d);
        pull_scaled_o <= scale_pull(tune_word_o,
                                    range_to_quarter_ppm(range_d));
        tune_update_o <= 1'b1;
      end
    end
  end

  // output enable source select
  always @(posedge clock_i) begin
    if (!rstn_i)
      output_enable_o <= 1'b0;
    else if (sw_oe_mode_i)
      output_enable_o <= oe_q;
    else
      output_enable_o <= oe_pin_sync_q;
  end

  // read port: one cycle latency, unmapped addresses read zero
  always @(posedge clock_i) begin
    if (!rstn_i) begin
      reg_rdata_o  <= {DATA_W{1'b0}};
      reg_rvalid_o <= 1'b0;
    end else begin
      reg_rvalid_o <= reg_rd_i;
      if (reg_rd_i) begin
        case (reg_addr_i)
          `DPC_ADDR_LOWER: reg_rdata_o <= lower_q;
          `DPC_ADDR_UPPER: reg_rdata_o <= {5'h00, oe_q, upper_q};
          `DPC_ADDR_RANGE: reg_rdata_o <= {12'h000, range_q};
          default:         reg_rdata_o <= {DATA_W{1'b0}};
        endcase
      end
    end
  end

endmodule

// >>> tb/dpc_checker.sv
// port assertions for the register bank
`timescale 1ns/1ps
module dpc_chk (
  input logic               clock_i,
  input logic               rstn_i,
  input logic               reg_wr_i,
  input logic [7:0]         reg_addr_i,
  input logic [15:0]        reg_wdata_i,
  input logic [15:0]        reg_rdata_o,
  input logic               reg_rvalid_o,
  input logic               sw_oe_mode_i,
  input logic               oe_pin_i,
  input logic               output_enable_o,
  input logic signed [25:0] tune_word_o,
  input logic [3:0]         range_code_o,
  input logic [13:0]        half_range_o,
  input logic signed [39:0] pull_scaled_o,
  input logic               tune_update_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!rstn_i);
  wire wu = reg_wr_i && reg_addr_i == 8'h01;
  wire wg = reg_wr_i && reg_addr_i == 8'h02;
  a_upper_pad_zero: assert property (
    reg_rvalid_o && $past(reg_addr_i) == 8'h01 |-> reg_rdata_o[15:11] == 5'h00)
    else $error("upper pad bits set");
  a_range_pad_zero: assert property (
    reg_rvalid_o && $past(reg_addr_i) == 8'h02
      |-> reg_rdata_o[15:4] == 12'h000)
    else $error("range pad bits set");
  a_upper_commit: assert property (
    wu |=> tune_update_o && tune_word_o[25:16] == $past(reg_wdata_i[9:0]))
    else $error("upper write not committed");
  a_tune_hold: assert property (!wu |=> $stable(tune_word_o))
    else $error("tune word moved without upper write");
  a_atomic_set: assert property (
    tune_update_o
      |-> pull_scaled_o == tune_word_o * $signed({1'h0, half_range_o}))
    else $error("scaled pull not consistent");
  a_range_load: assert property (
    wg |=> tune_update_o && range_code_o == $past(reg_wdata_i[3:0]))
    else $error("range write not committed");
  a_sw_oe_bit: assert property (
    sw_oe_mode_i && wu |=> ##1 output_enable_o == $past(reg_wdata_i[10], 2))
    else $error("software enable not applied");
  a_pin_oe: assert property (
    !sw_oe_mode_i [*3] |-> output_enable_o == $past(oe_pin_i, 3))
    else $error("pin enable not followed");
  c_upper: cover property (wu ##1 tune_update_o);
  c_range: cover property (wg ##1 tune_update_o);
  c_pin: cover property (!sw_oe_mode_i && $rose(output_enable_o));
endmodule
bind dpc_regs dpc_chk u_chk (.*);

// >>> tb/dpc_host.sv
// host model issuing register strobes
`timescale 1ns/1ps
module dpc_host (
  input  logic        clock_i,
  input  logic [15:0] reg_rdata_o,
  input  logic        reg_rvalid_o,
  output logic        reg_wr_i = 1'h0,
  output logic        reg_rd_i = 1'h0,
  output logic [7:0]  reg_addr_i = 8'h00,
  output logic [15:0] reg_wdata_i = 16'h0000
);
  // released lines show the inverse so stale values cannot pass
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clock_i);
    reg_wr_i <= 1'h1;
    reg_addr_i <= a;
    reg_wdata_i <= v;
    @(posedge clock_i);
    reg_wr_i <= 1'h0;
    reg_addr_i <= ~a;
    reg_wdata_i <= ~v;
  endtask
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clock_i);
    reg_rd_i <= 1'h1;
    reg_addr_i <= a;
    @(posedge clock_i);
    reg_rd_i <= 1'h0;
    reg_addr_i <= ~a;
    @(posedge clock_i);
    v = reg_rvalid_o ? reg_rdata_o : 16'hXXXX;
  endtask
  task automatic tune(input logic [15:0] l, input logic [15:0] u);
    wr(8'h00, l);
    wr(8'h01, u);
    repeat (530) @(posedge clock_i);
  endtask
endmodule

// >>> tb/tb_top.sv
// self-checking bench for the register bank
`timescale 1ns/1ps
module tb_top;
  logic clock_i, rstn_i, reg_wr_i, reg_rd_i, reg_rvalid_o, tune_update_o;
  logic sw_oe_mode_i, oe_pin_i, output_enable_o;
  logic [7:0] reg_addr_i;
  logic [15:0] reg_wdata_i, reg_rdata_o, d;
  logic [3:0] factory_range_i, range_code_o;
  logic [13:0] half_range_o;
  logic signed [25:0] tune_word_o;
  logic signed [39:0] pull_scaled_o;
  logic [31:0] seed = 32'h5360EE60;
  int miscompares, n_checks, cyc, lo, up, oe, rg, cw;
  int hr[16] = '{25, 40, 50, 100, 200, 320, 400, 500, 600, 800, 1600, 2400,
                 3200, 4800, 6400, 12800};
  dpc_regs dut (.*);
  dpc_host host (.*);
  function automatic logic [31:0] lfsr();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  task automatic chk_out(input logic [39:0] g, input logic [39:0] e);
    n_checks++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %0t got %h want %h", $time, g, e);
    end
  endtask
  task automatic chk_rd(input logic [15:0] g, input logic [15:0] e);
    chk_out({24'h000000, g}, {24'h000000, e});
  endtask
  task automatic outs();
    chk_out(40'(tune_word_o), 40'(cw));
    chk_out(40'(range_code_o), 40'(rg));
    chk_out(40'(half_range_o), 40'(hr[rg]));
    chk_out(pull_scaled_o, 40'(longint'(cw) * hr[rg]));
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clock_i = 1'h0;
    forever #25 clock_i = ~clock_i;
  end
  always @(posedge clock_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  initial begin
    rstn_i = 1'h0;
    sw_oe_mode_i = 1'h1;
    oe_pin_i = 1'h0;
    factory_range_i = 4'(lfsr());
    repeat (8) @(posedge clock_i);
    rstn_i <= 1'h1;
    rg = factory_range_i;
    host.rd(8'h01, d);
    chk_rd(d, 16'h0000);
    host.rd(8'h02, d);
    chk_rd(d, 16'(rg));
    outs();
    $display("done: reset");
    for (int i = 0; i < 6; i++) begin
      lo = i == 0 ? 0 : i == 1 ? 'hFFFF : lfsr() & 'hFFFF;
      up = i == 0 ? 'h0200 : i == 1 ? 'hF9FF : lfsr() & 'hFFFF;
      host.tune(16'(lo), 16'(up));
      oe = up >> 10 & 1;
      up = up & 'h3FF;
      cw = ((up << 16 | lo) << 6) >>> 6;
      outs();
      host.rd(8'h01, d);
      chk_rd(d, 16'(oe << 10 | up));
      chk_out(40'(output_enable_o), 40'(oe));
    end
    lo = 'h5A5A;
    host.wr(8'h00, 16'h5A5A);
    // one more edge so a wrongful commit on the strobe edge shows
    @(posedge clock_i);
    outs();
    $display("done: tune");
    for (int c = 0; c < 16; c++) begin
      host.wr(8'h02, 16'(lfsr()) & 16'hFFF0 | 16'(c));
      @(posedge clock_i);
      rg = c;
      outs();
      host.rd(8'h02, d);
      chk_rd(d, 16'(c));
    end
    $display("done: range");
    sw_oe_mode_i <= 1'h0;
    for (int i = 0; i < 4; i++) begin
      oe_pin_i <= i[0];
      host.tune(16'(lo), 16'(up | (i[0] ? 0 : 'h400)));
      chk_out(40'(output_enable_o), 40'(i[0]));
    end
    cw = ((up << 16 | lo) << 6) >>> 6;
    outs();
    host.rd(8'h05, d);
    chk_rd(d, 16'h0000);
    $display("done: enable");
    tally_and_finish();
  end
endmodule
